//--- hw/core_timing_defs.vh
`ifndef CORE_TIMING_DEFS_VH
`define CORE_TIMING_DEFS_VH

// ----------------------------------------
// Core register addresses in direct space
// ----------------------------------------
`define ADDR_ACC 8'he0
`define ADDR_AUX_B 8'hf0
`define ADDR_STATUS 8'hd0
`define ADDR_PTR_LO 8'h82
`define ADDR_PTR_HI 8'h83

// ----------------------------------------
// Status word fields and reset values
// ----------------------------------------
`define STAT_CY 7
`define STAT_AC 6
`define STAT_OV 2
`define STAT_BANK_HI 4
`define STAT_BANK_LO 3
`define STAT_RESET 8'h00
`define PC_RESET 16'h0000
`define ACC_RESET 8'h00

// ----------------------------------------
// Cycle counts of the long instructions
// ----------------------------------------
`define CYC_MULTIPLY 4'h4
`define CYC_DIVIDE 4'h8
`define CYC_CODE_ACCESS 4'h3

// ----------------------------------------
// Opcode groups (upper nibble) and opcodes
// ----------------------------------------
`define HI_ADD 4'h2
`define HI_ADD_CY 4'h3
`define HI_SUB_BR 4'h9
`define HI_OR 4'h4
`define HI_AND 4'h5
`define HI_XOR 4'h6
`define HI_MOVE_A 4'he
`define OP_INC_A 8'h04
`define OP_DEC_A 8'h14
`define OP_CLR_A 8'he4
`define OP_MOV_A_IMM 8'h74
`define OP_MOV_DIR_A 8'hf5
`define OP_LOAD_PTR 8'h90
`define OP_INC_PTR 8'ha3
`define OP_CODE_READ 8'h93
`define OP_EXT_READ 8'he0
`define OP_EXT_WRITE 8'hf0
`define OP_MULTIPLY 8'ha4
`define OP_DIVIDE 8'h84
`define OP_SHORT_JMP 8'h80
`define OP_LONG_JMP 8'h02
`define OP_JMP_CY 8'h40
`define OP_JMP_NCY 8'h50
`define OP_JMP_Z 8'h60
`define OP_JMP_NZ 8'h70

`endif

//--- hw/pipelined_core.v
`include "core_timing_defs.vh"
`timescale 1ns/100ps
`default_nettype none

module pipelined_core (
    input wire ref_clk,
    input wire srst,
    output wire [15:0] code_addr,
    input wire [7:0] code_rdata,
    output wire flash_wr_en,
    output wire [15:0] flash_wr_addr,
    output wire [7:0] flash_wr_data,
    output wire [7:0] periph_rd_addr,
    input wire [7:0] periph_rdata,
    output wire periph_we,
    output wire [7:0] periph_wr_addr,
    output wire [7:0] periph_wdata,
    input wire dbg_halt_req,
    input wire dbg_run_req,
    input wire dbg_step_req,
    input wire bkpt_en,
    input wire [15:0] bkpt_addr,
    input wire [7:0] dbg_ram_addr,
    input wire dbg_ram_we,
    input wire [7:0] dbg_ram_wdata,
    output wire [7:0] dbg_ram_rdata,
    output wire dbg_halted,
    output wire [15:0] dbg_pc,
    output wire [7:0] dbg_acc,
    output wire retire,
    output wire [3:0] retire_cycles
);

// ----------------------------------------
// State
// ----------------------------------------
reg [15:0] pc_reg;
reg [3:0] cyc_reg;
reg [7:0] opcode_reg;
reg [7:0] op1_reg;
reg [7:0] op2_reg;
reg [7:0] acc_reg;
reg [7:0] aux_b_reg;
reg [7:0] program_status_word_reg;
reg [15:0] sixteen_bit_pointer_reg;
reg [7:0] ram_mem [0:255];
reg halted_reg;
reg step_reg;
reg skip_bkpt_reg;
reg retire_reg;
reg [3:0] retire_cycles_reg;
reg flash_wr_en_reg;
reg [15:0] flash_wr_addr_reg;
reg [7:0] flash_wr_data_reg;
reg periph_we_reg;
reg [7:0] periph_wr_addr_reg;
reg [7:0] periph_wdata_reg;
reg [7:0] dbg_ram_rdata_reg;

// Opcode is live on the fetch bus in cycle 0, held afterwards
wire [7:0] cur_op = (cyc_reg == 4'h0) ? code_rdata : opcode_reg;
wire [7:0] b1 = (cyc_reg == 4'h1) ? code_rdata : op1_reg;
wire [7:0] b2 = (cyc_reg == 4'h2) ? code_rdata : op2_reg;
wire [3:0] hi = cur_op[7:4];
wire [3:0] lo = cur_op[3:0];
wire cy = program_status_word_reg[`STAT_CY];
wire [7:0] psw_rd = {program_status_word_reg[7:1], ^acc_reg};
wire [7:0] wreg_addr = {3'b000, program_status_word_reg[`STAT_BANK_HI:`STAT_BANK_LO], cur_op[2:0]};
wire [7:0] wreg_val = ram_mem[wreg_addr];
wire [7:0] ind_ptr = ram_mem[{3'b000, program_status_word_reg[`STAT_BANK_HI:`STAT_BANK_LO],
    2'b00, cur_op[0]}];
wire [7:0] ind_val = ram_mem[ind_ptr];
wire arith_hi = (hi == `HI_ADD) || (hi == `HI_ADD_CY) || (hi == `HI_SUB_BR);
wire logic_hi = (hi == `HI_OR) || (hi == `HI_AND) || (hi == `HI_XOR);
wire alu_grp = (logic_hi && lo >= 4'h2) || (arith_hi && lo >= 4'h4)
    || (hi == `HI_MOVE_A && lo >= 4'h5);
wire dir_form = logic_hi && (lo == 4'h2 || lo == 4'h3);
wire code_acc = (cur_op == `OP_CODE_READ) || (cur_op == `OP_EXT_READ)
    || (cur_op == `OP_EXT_WRITE);

// ----------------------------------------
// Length and timing decode
// ----------------------------------------
reg [1:0] nb;
reg [3:0] nc;
reg jmp;
reg cond;

// Bytes and base clocks per opcode; untaken branch is the base
always @* begin
    nb = 2'h1;
    nc = 4'h1;
    jmp = 1'b0;
    cond = 1'b0;
    if (alu_grp) begin
        if (lo[3]) begin
            nb = 2'h1;
            nc = 4'h1;
        end else begin
            case (lo[2:0])
                3'h2, 3'h4, 3'h5: begin
                    nb = 2'h2;
                    nc = 4'h2;
                end
                3'h3: begin
                    nb = 2'h3;
                    nc = 4'h3;
                end
                3'h6, 3'h7: begin
                    nb = 2'h1;
                    nc = 4'h2;
                end
                default: begin
                    nb = 2'h1;
                    nc = 4'h1;
                end
            endcase
        end
    end else begin
        case (cur_op)
            `OP_MULTIPLY: nc = `CYC_MULTIPLY;
            `OP_DIVIDE: nc = `CYC_DIVIDE;
            `OP_CODE_READ, `OP_EXT_READ, `OP_EXT_WRITE: nc = `CYC_CODE_ACCESS;
            `OP_LOAD_PTR: begin
                nb = 2'h3;
                nc = 4'h3;
            end
            `OP_MOV_A_IMM, `OP_MOV_DIR_A: begin
                nb = 2'h2;
                nc = 4'h2;
            end
            `OP_SHORT_JMP: begin
                nb = 2'h2;
                nc = 4'h2;
                jmp = 1'b1;
                cond = 1'b1;
            end
            `OP_JMP_CY, `OP_JMP_NCY, `OP_JMP_Z, `OP_JMP_NZ: begin
                nb = 2'h2;
                nc = 4'h2;
                jmp = 1'b1;
                case (cur_op)
                    `OP_JMP_CY: cond = cy;
                    `OP_JMP_NCY: cond = ~cy;
                    `OP_JMP_Z: cond = (acc_reg == 8'h00);
                    default: cond = (acc_reg != 8'h00);
                endcase
            end
            `OP_LONG_JMP: begin
                nb = 2'h3;
                nc = 4'h3;
                jmp = 1'b1;
                cond = 1'b1;
            end
            default: ;
        endcase
    end
end

// Taken branch costs one more clock to refetch at the target
wire taken = jmp & cond;
wire [3:0] nc_eff = nc + {3'b000, taken};
wire [15:0] target = (cur_op == `OP_LONG_JMP) ? {op1_reg, op2_reg}
    : pc_reg + {{8{op1_reg[7]}}, op1_reg};

// ----------------------------------------
// Debug run control
// ----------------------------------------
// Halt decisions only at an instruction boundary
wire bkpt_hit = bkpt_en && (pc_reg == bkpt_addr) && !skip_bkpt_reg;
wire go = !halted_reg && !dbg_halt_req && !bkpt_hit;
wire active = (cyc_reg != 4'h0) || go;
wire last_cyc = active && (cyc_reg == nc_eff - 4'h1);

// ----------------------------------------
// Operand fetch and ALU
// ----------------------------------------
reg [7:0] dir_val;
reg [7:0] src;
reg [7:0] x;
reg [7:0] y;
reg [7:0] alu_r;
reg [8:0] sum9;
reg [4:0] nib5;
reg cin;
reg alu_cy;
reg alu_ac;
reg alu_ov;

// Direct space: low half is RAM, high half core or peripheral regs
always @* begin
    case (b1)
        `ADDR_ACC: dir_val = acc_reg;
        `ADDR_AUX_B: dir_val = aux_b_reg;
        `ADDR_STATUS: dir_val = psw_rd;
        `ADDR_PTR_LO: dir_val = sixteen_bit_pointer_reg[7:0];
        `ADDR_PTR_HI: dir_val = sixteen_bit_pointer_reg[15:8];
        default: dir_val = b1[7] ? periph_rdata : ram_mem[b1];
    endcase
end

// Source by addressing mode, then arithmetic with flag rules
always @* begin
    if (lo[3]) begin
        src = wreg_val;
    end else if (lo == 4'h4) begin
        src = b1;
    end else if (lo == 4'h6 || lo == 4'h7) begin
        src = ind_val;
    end else begin
        src = dir_val;
    end
    x = dir_form ? dir_val : acc_reg;
    y = dir_form ? ((lo == 4'h2) ? acc_reg : b2) : src;
    cin = (hi == `HI_ADD_CY || hi == `HI_SUB_BR) ? cy : 1'b0;
    sum9 = 9'h000;
    nib5 = 5'h00;
    alu_r = y;
    alu_cy = cy;
    alu_ac = program_status_word_reg[`STAT_AC];
    alu_ov = program_status_word_reg[`STAT_OV];
    case (hi)
        `HI_ADD, `HI_ADD_CY: begin
            sum9 = {1'b0, x} + {1'b0, y} + {8'h00, cin};
            nib5 = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, cin};
            alu_r = sum9[7:0];
            alu_cy = sum9[8];
            alu_ac = nib5[4];
            alu_ov = (x[7] == y[7]) && (sum9[7] != x[7]);
        end
        `HI_SUB_BR: begin
            sum9 = {1'b0, x} - {1'b0, y} - {8'h00, cin};
            nib5 = {1'b0, x[3:0]} - {1'b0, y[3:0]} - {4'h0, cin};
            alu_r = sum9[7:0];
            alu_cy = sum9[8];
            alu_ac = nib5[4];
            alu_ov = (x[7] != y[7]) && (sum9[7] != x[7]);
        end
        `HI_OR: alu_r = x | y;
        `HI_AND: alu_r = x & y;
        `HI_XOR: alu_r = x ^ y;
        default: alu_r = y;
    endcase
end

// ----------------------------------------
// Execute: write-back selection
// ----------------------------------------
wire [15:0] prod = acc_reg * aux_b_reg;
reg acc_we;
reg [7:0] acc_d;
reg b_we;
reg [7:0] b_d;
reg ptr_we;
reg [15:0] ptr_d;
reg dw_en;
reg [7:0] dw_addr;
reg [7:0] dw_data;
reg [2:0] fl_we;
reg [2:0] fl_d;

// Each instruction makes at most one direct-space write
always @* begin
    acc_we = 1'b0;
    acc_d = alu_r;
    b_we = 1'b0;
    b_d = aux_b_reg;
    ptr_we = 1'b0;
    ptr_d = sixteen_bit_pointer_reg + 16'h0001;
    dw_en = 1'b0;
    dw_addr = b1;
    dw_data = alu_r;
    fl_we = 3'b000;
    fl_d = {alu_cy, alu_ac, alu_ov};
    if (alu_grp) begin
        dw_en = dir_form;
        acc_we = ~dir_form;
        fl_we = arith_hi ? 3'b111 : 3'b000;
    end else begin
        casez (cur_op)
            `OP_INC_A: begin
                acc_we = 1'b1;
                acc_d = acc_reg + 8'h01;
            end
            `OP_DEC_A: begin
                acc_we = 1'b1;
                acc_d = acc_reg - 8'h01;
            end
            8'b0000_1???: begin
                dw_en = 1'b1;
                dw_addr = wreg_addr;
                dw_data = wreg_val + 8'h01;
            end
            8'b0001_1???: begin
                dw_en = 1'b1;
                dw_addr = wreg_addr;
                dw_data = wreg_val - 8'h01;
            end
            8'b1111_1???: begin
                dw_en = 1'b1;
                dw_addr = wreg_addr;
                dw_data = acc_reg;
            end
            `OP_CLR_A: begin
                acc_we = 1'b1;
                acc_d = 8'h00;
            end
            `OP_MOV_DIR_A: begin
                dw_en = 1'b1;
                dw_data = acc_reg;
            end
            `OP_MOV_A_IMM: begin
                acc_we = 1'b1;
                acc_d = b1;
            end
            `OP_LOAD_PTR: begin
                ptr_we = 1'b1;
                ptr_d = {b1, b2};
            end
            `OP_INC_PTR: ptr_we = 1'b1;
            `OP_CODE_READ, `OP_EXT_READ: begin
                acc_we = 1'b1;
                acc_d = op1_reg;
            end
            `OP_MULTIPLY: begin
                acc_we = 1'b1;
                acc_d = prod[7:0];
                b_we = 1'b1;
                b_d = prod[15:8];
                fl_we = 3'b101;
                fl_d = {1'b0, alu_ac, |prod[15:8]};
            end
            `OP_DIVIDE: begin
                fl_we = 3'b101;
                fl_d = {1'b0, alu_ac, aux_b_reg == 8'h00};
                if (aux_b_reg != 8'h00) begin
                    acc_we = 1'b1;
                    acc_d = acc_reg / aux_b_reg;
                    b_we = 1'b1;
                    b_d = acc_reg % aux_b_reg;
                end
            end
            default: ;
        endcase
    end
end

// ----------------------------------------
// Sequencer and architectural registers
// ----------------------------------------
// One byte per clock; a taken branch reloads the fetch address
always @(posedge ref_clk) begin
    if (srst) begin
        pc_reg <= `PC_RESET;
        cyc_reg <= 4'h0;
        opcode_reg <= 8'h00;
        op1_reg <= 8'h00;
        op2_reg <= 8'h00;
        acc_reg <= `ACC_RESET;
        aux_b_reg <= 8'h00;
        program_status_word_reg <= `STAT_RESET;
        sixteen_bit_pointer_reg <= 16'h0000;
        retire_reg <= 1'b0;
        retire_cycles_reg <= 4'h0;
        flash_wr_en_reg <= 1'b0;
        flash_wr_addr_reg <= 16'h0000;
        flash_wr_data_reg <= 8'h00;
        periph_we_reg <= 1'b0;
        periph_wr_addr_reg <= 8'h00;
        periph_wdata_reg <= 8'h00;
    end else begin
        retire_reg <= 1'b0;
        flash_wr_en_reg <= 1'b0;
        periph_we_reg <= 1'b0;
        if (active) begin
            if (cyc_reg == 4'h0) opcode_reg <= code_rdata;
            if (cyc_reg == 4'h1) op1_reg <= code_rdata;
            if (cyc_reg == 4'h2) op2_reg <= code_rdata;
            if (cyc_reg < {2'b00, nb}) pc_reg <= pc_reg + 16'h0001;
            if (cyc_reg == 4'h1 && cur_op == `OP_EXT_WRITE) begin
                flash_wr_en_reg <= 1'b1;
                flash_wr_addr_reg <= sixteen_bit_pointer_reg;
                flash_wr_data_reg <= acc_reg;
            end
            if (last_cyc) begin
                cyc_reg <= 4'h0;
                retire_reg <= 1'b1;
                retire_cycles_reg <= nc_eff;
                if (taken) pc_reg <= target;
                if (acc_we) acc_reg <= acc_d;
                if (b_we) aux_b_reg <= b_d;
                if (ptr_we) sixteen_bit_pointer_reg <= ptr_d;
                if (fl_we[2]) program_status_word_reg[`STAT_CY] <= fl_d[2];
                if (fl_we[1]) program_status_word_reg[`STAT_AC] <= fl_d[1];
                if (fl_we[0]) program_status_word_reg[`STAT_OV] <= fl_d[0];
                if (dw_en) begin
                    case (dw_addr)
                        `ADDR_ACC: acc_reg <= dw_data;
                        `ADDR_AUX_B: aux_b_reg <= dw_data;
                        `ADDR_STATUS: program_status_word_reg <= dw_data;
                        `ADDR_PTR_LO: sixteen_bit_pointer_reg[7:0] <= dw_data;
                        `ADDR_PTR_HI: sixteen_bit_pointer_reg[15:8] <= dw_data;
                        default: begin
                            periph_we_reg <= dw_addr[7];
                            periph_wr_addr_reg <= dw_addr;
                            periph_wdata_reg <= dw_data;
                        end
                    endcase
                end
            end else begin
                cyc_reg <= cyc_reg + 4'h1;
            end
        end
    end
end

// RAM; debugger writes land only while the core is halted, debugger reads work at any time
always @(posedge ref_clk) begin
    if (halted_reg && dbg_ram_we) begin
        ram_mem[dbg_ram_addr] <= dbg_ram_wdata;
    end else if (last_cyc && dw_en && !dw_addr[7]) begin
        ram_mem[dw_addr] <= dw_data;
    end
end

// Stop, run and single step; step halts after one retirement
always @(posedge ref_clk) begin
    if (srst) begin
        halted_reg <= 1'b0;
        step_reg <= 1'b0;
        skip_bkpt_reg <= 1'b0;
        dbg_ram_rdata_reg <= 8'h00;
    end else begin
        dbg_ram_rdata_reg <= ram_mem[dbg_ram_addr];
        if (halted_reg) begin
            if (dbg_step_req) begin
                halted_reg <= 1'b0;
                step_reg <= 1'b1;
                skip_bkpt_reg <= 1'b1;
            end else if (dbg_run_req) begin
                halted_reg <= 1'b0;
                skip_bkpt_reg <= 1'b1;
            end
        end else begin
            if (cyc_reg == 4'h0 && !go) halted_reg <= 1'b1;
            if (last_cyc) begin
                skip_bkpt_reg <= 1'b0;
                if (step_reg) begin
                    halted_reg <= 1'b1;
                    step_reg <= 1'b0;
                end
            end
        end
    end
end

// ----------------------------------------
// Outputs
// ----------------------------------------
// Only on-chip flash is addressed; no external memory bus exists
assign code_addr = (active && cyc_reg == 4'h1 && code_acc)
    ? (sixteen_bit_pointer_reg + ((cur_op == `OP_CODE_READ) ? {8'h00, acc_reg} : 16'h0000))
    : pc_reg;
assign flash_wr_en = flash_wr_en_reg;
assign flash_wr_addr = flash_wr_addr_reg;
assign flash_wr_data = flash_wr_data_reg;
assign periph_rd_addr = b1;
assign periph_we = periph_we_reg;
assign periph_wr_addr = periph_wr_addr_reg;
assign periph_wdata = periph_wdata_reg;
assign dbg_ram_rdata = dbg_ram_rdata_reg;
assign dbg_halted = halted_reg;
assign dbg_pc = pc_reg;
assign dbg_acc = acc_reg;
assign retire = retire_reg;
assign retire_cycles = retire_cycles_reg;

endmodule // pipelined_core

`default_nettype wire

//--- test/core_timing_checker.sv
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------
// Timing and debug checker
// ----------------------------------------
module core_timing_checker (
    input wire ref_clk,
    input wire srst,
    input wire flash_wr_en,
    input wire dbg_run_req,
    input wire dbg_step_req,
    input wire dbg_halted,
    input wire [15:0] dbg_pc,
    input wire retire,
    input wire [3:0] retire_cycles
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);

    logic [3:0] gap_reg;
    logic gap_ok_reg;

    // Clocks since last retire; any halt spoils the gap
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            gap_reg <= 4'h0;
            gap_ok_reg <= 1'b0;
        end else if (retire) begin
            gap_reg <= 4'h1;
            gap_ok_reg <= !dbg_halted;
        end else begin
            gap_reg <= gap_reg + 4'h1;
            gap_ok_reg <= gap_ok_reg && !dbg_halted;
        end
    end

    sequence s_one_instr;
        !dbg_halted ##[1:8] (dbg_halted && retire);
    endsequence
    sequence s_wr_done;
        !flash_wr_en && retire && retire_cycles == 4'h3;
    endsequence

    property p_max_cycles;
        retire |-> retire_cycles != 4'h0 && retire_cycles <= 4'h8;
    endproperty
    property p_gap;
        retire && gap_ok_reg |-> gap_reg == retire_cycles;
    endproperty
    property p_wr_seq;
        flash_wr_en |=> s_wr_done;
    endproperty
    property p_halt_hold;
        dbg_halted && !dbg_run_req && !dbg_step_req |=> dbg_halted && $stable(dbg_pc);
    endproperty
    property p_halt_quiet;
        dbg_halted && $past(dbg_halted) |-> !retire && !flash_wr_en;
    endproperty
    property p_run;
        dbg_halted && dbg_run_req && !dbg_step_req |=> !dbg_halted;
    endproperty
    property p_step;
        dbg_halted && dbg_step_req |=> s_one_instr;
    endproperty
    property p_count_held;
        !retire |-> $stable(retire_cycles);
    endproperty

    a_max_cycles: assert property (p_max_cycles)
        else $error("retire count out of range");
    a_gap: assert property (p_gap)
        else $error("retire spacing differs from count");
    a_wr_seq: assert property (p_wr_seq)
        else $error("flash write not followed by 3 clock retire");
    a_halt_hold: assert property (p_halt_hold)
        else $error("halt not held");
    a_halt_quiet: assert property (p_halt_quiet)
        else $error("activity while halted");
    a_run: assert property (p_run)
        else $error("run request ignored");
    a_step: assert property (p_step)
        else $error("single step did not end halted");
    a_count_held: assert property (p_count_held)
        else $error("retire count changed without retire");
endmodule // core_timing_checker

bind pipelined_core core_timing_checker chk (
    .ref_clk(ref_clk),
    .srst(srst),
    .flash_wr_en(flash_wr_en),
    .dbg_run_req(dbg_run_req),
    .dbg_step_req(dbg_step_req),
    .dbg_halted(dbg_halted),
    .dbg_pc(dbg_pc),
    .retire(retire),
    .retire_cycles(retire_cycles)
);

`default_nettype wire

//--- test/flash_model.sv
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------
// Program flash partner
// ----------------------------------------
module flash_model (
    input wire ref_clk,
    input wire [15:0] code_addr,
    output logic [7:0] code_rdata,
    input wire flash_wr_en,
    input wire [15:0] flash_wr_addr,
    input wire [7:0] flash_wr_data
);
    logic [7:0] mem [0:65535];

    // Erased flash reads all ones
    initial begin
        for (int i = 0; i < 65536; i++) begin
            mem[i] = 8'hff;
        end
    end

    // Asynchronous byte read, code and data alike
    assign code_rdata = mem[code_addr];

    // Byte write; no erase modelled, a trade for brevity
    always @(posedge ref_clk) begin
        if (flash_wr_en) begin
            mem[flash_wr_addr] <= flash_wr_data;
        end
    end
endmodule // flash_model

`default_nettype wire

//--- test/pipelined_8bit_cpu_timing_tb.sv
`timescale 1ns/100ps
`default_nettype none

`define CHK(nm, exp, got) \
    begin \
        compares++; \
        if ((exp) !== (got)) begin \
            n_fail++; \
            $display("BAD %s expected %h seen %h", nm, exp, got); \
        end \
    end

module pipelined_8bit_cpu_timing_tb;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] periph_rdata = 8'h00;
    logic dbg_halt_req = 1'b0;
    logic dbg_run_req = 1'b0;
    logic dbg_step_req = 1'b0;
    logic bkpt_en = 1'b0;
    logic [15:0] bkpt_addr = 16'h0000;
    logic [7:0] dbg_ram_addr = 8'h00;
    logic dbg_ram_we = 1'b0;
    logic [7:0] dbg_ram_wdata = 8'h00;
    wire [15:0] code_addr;
    wire [7:0] code_rdata;
    wire flash_wr_en;
    wire [15:0] flash_wr_addr;
    wire [7:0] flash_wr_data;
    wire [7:0] dbg_ram_rdata;
    wire dbg_halted;
    wire [15:0] dbg_pc;
    wire [7:0] dbg_acc;
    wire retire;
    wire [3:0] retire_cycles;
    int n_fail = 0;
    int compares = 0;
    int wr_seen = 0;
    int ec;
    int exp_q[$];
    logic [7:0] k, m, n, exp_acc, v1;
    logic [15:0] ptr;
    logic [7:0] prog [0:22];

    initial begin
        forever #5 ref_clk = ~ref_clk;
    end

    pipelined_core DUT (
        .ref_clk(ref_clk), .srst(srst), .code_addr(code_addr), .code_rdata(code_rdata),
        .flash_wr_en(flash_wr_en), .flash_wr_addr(flash_wr_addr),
        .flash_wr_data(flash_wr_data), .periph_rd_addr(), .periph_rdata(periph_rdata),
        .periph_we(), .periph_wr_addr(), .periph_wdata(), .dbg_halt_req(dbg_halt_req),
        .dbg_run_req(dbg_run_req), .dbg_step_req(dbg_step_req), .bkpt_en(bkpt_en),
        .bkpt_addr(bkpt_addr), .dbg_ram_addr(dbg_ram_addr), .dbg_ram_we(dbg_ram_we),
        .dbg_ram_wdata(dbg_ram_wdata), .dbg_ram_rdata(dbg_ram_rdata),
        .dbg_halted(dbg_halted), .dbg_pc(dbg_pc), .dbg_acc(dbg_acc), .retire(retire),
        .retire_cycles(retire_cycles)
    );

    flash_model flash (
        .ref_clk(ref_clk), .code_addr(code_addr), .code_rdata(code_rdata),
        .flash_wr_en(flash_wr_en), .flash_wr_addr(flash_wr_addr),
        .flash_wr_data(flash_wr_data)
    );

    // ----------------------------------------
    // Reference model: clock count per retire
    // ----------------------------------------
    always @(negedge ref_clk) begin
        periph_rdata <= 8'($urandom);
        if (!srst && retire === 1'b1) begin
            ec = (exp_q.size() > 0) ? exp_q.pop_front() : 3;
            `CHK("retire_cycles", 4'(ec), retire_cycles)
        end
        if (!srst && flash_wr_en === 1'b1) begin
            wr_seen++;
            `CHK("flash_wr_addr", ptr, flash_wr_addr)
            `CHK("flash_wr_data", exp_acc, flash_wr_data)
        end
    end

    task automatic end_sim();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Bounded wait for the halt flag
    task automatic wait_halt();
        for (int i = 0; i < 40 && dbg_halted !== 1'b1; i++) begin
            @(negedge ref_clk);
        end
        `CHK("dbg_halted", 1'b1, dbg_halted)
        `CHK("dbg_pc", 16'h0015, dbg_pc)
    endtask

    // Debug RAM access; data shows one clock later
    task automatic ram_acc(input logic [7:0] a, input logic [7:0] d, input logic we);
        dbg_ram_addr = a;
        dbg_ram_wdata = d;
        dbg_ram_we = we;
        @(negedge ref_clk);
        dbg_ram_we = 1'b0;
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        k = 8'($urandom(36));
        m = 8'($urandom);
        n = 8'($urandom);
        v1 = 8'($urandom);
        ptr = {8'($urandom_range(255, 1)), 8'($urandom)};
        exp_acc = (k + m) & n;
        // Mul/div by zero B, arithmetic, write, branches, read back, loop
        prog = '{8'ha4, 8'h84, 8'h74, k, 8'h24, m, 8'h04, 8'h14, 8'h54, n, 8'h90,
                 ptr[15:8], ptr[7:0], 8'hf0, 8'he4, 8'h70, 8'h05, 8'h60, 8'h01, 8'h00,
                 8'h93, 8'h80, 8'hfe};
        exp_q = '{4, 8, 2, 2, 1, 1, 2, 3, 3, 1, 2, 3, 3};
        repeat (9) @(negedge ref_clk);
        for (int i = 0; i < 23; i++) begin
            flash.mem[i] = prog[i];
        end
        `CHK("reset pc", 16'h0000, dbg_pc)
        `CHK("reset acc", 8'h00, dbg_acc)
        @(negedge ref_clk) srst = 1'b0;
        for (int i = 0; i < 100 && exp_q.size() > 0; i++) begin
            @(negedge ref_clk);
        end
        dbg_halt_req = 1'b1;
        @(negedge ref_clk);
        wait_halt();
        dbg_halt_req = 1'b0;
        `CHK("dbg_acc", exp_acc, dbg_acc)
        `CHK("flash writes", 1, wr_seen)
        ram_acc(8'h30, v1, 1'b1);
        ram_acc(8'h30, 8'h00, 1'b0);
        `CHK("dbg_ram_rdata", v1, dbg_ram_rdata)
        dbg_step_req = 1'b1;
        @(negedge ref_clk) dbg_step_req = 1'b0;
        wait_halt();
        bkpt_addr = 16'h0015;
        bkpt_en = 1'b1;
        dbg_run_req = 1'b1;
        @(negedge ref_clk) dbg_run_req = 1'b0;
        ram_acc(8'h30, ~v1, 1'b1);
        wait_halt();
        ram_acc(8'h30, 8'h00, 1'b0);
        `CHK("dbg_ram_rdata", v1, dbg_ram_rdata)
        end_sim();
    end

    // Watchdog well beyond the fewer than a hundred clocks needed
    initial begin
        repeat (3000) @(posedge ref_clk);
        n_fail++;
        end_sim();
    end
endmodule // pipelined_8bit_cpu_timing_tb

`default_nettype wire
